// file: rtl/usart_core.v
// Purpose: Host SPI engine and asynchronous receiver with a data FIFO.
// Assumes: Inputs synchronous to i_sys_clk; baud tick from outside.
// Notes: The FIFO buffers transmit bytes ahead of the shifter.
// Contract
// - Host SPI produces transfer clock, rate taken from the baud tick.
// - Each bit held one full clock period, sampled mid period.
// - Phase 0 samples leading, shifts trailing; phase 1 the reverse.
// - Inversion 0 leading edge rising; inversion 1 leading edge falling.
// - Transmission and its flags behave as in normal serial operation.
// - Receive error flags read zero in host SPI mode.
// - No write collision protection, double speed clock or multi host.
// - TX is MOSI, RX is MISO, transfer clock is SCK, no select.
// - Receiver oversamples 16 times normal, eight times double speed.
// - Start detection begins at falling edge; first low is sample one.
// - Samples 8,9,10 or 4,5,6 validate start by majority low.
// - Fewer than two lows reject start; check repeats each frame.
// - Each data bit decided by majority of three centre samples.
// - Only the first stop bit is sampled.
// - Low stop bit sets frame error for that frame.
// - Next start edge accepted right after stop bit vote samples.
// - Host SPI frames are exactly eight data bits, no framing bits.
// - Bit order select chooses LSB or MSB first in host SPI mode only; the receiver is always LSB first.
`timescale 1ns/1ps
`default_nettype none
`include "usart_core_map.vh"

module usart_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
)
(
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	// Full and empty come from the occupancy count.
	assign o_in_ready = (cnt_q != DEPTH);
	assign o_out_valid = (cnt_q != 0);
	assign o_out_data = mem_q[rd_q];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	// Pointers and count move on push and pop.
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// Storage is written without reset.
	always @(posedge i_sys_clk)
	begin
		if (push)
			mem_q[wr_q] <= i_in_data;
	end
endmodule

module usart_core (
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire i_baud_tick,
	input wire i_spi_mode,
	input wire i_pin_invert_select,
	input wire i_clock_phase_select,
	input wire i_bit_order_select,
	input wire i_receive_speed_mode,
	input wire i_tx_valid,
	output reg o_tx_ready,
	input wire [7:0] i_tx_data,
	output reg o_tx_done,
	output reg o_tx_empty,
	output reg o_rx_valid,
	output reg [7:0] o_rx_data,
	output reg o_rx_frame_err,
	output reg o_mosi,
	input wire i_miso,
	output reg o_transfer_clock_pin,
	input wire i_rxd
);
	localparam S_IDLE = 2'h0;
	localparam S_START = 2'h1;
	localparam S_DATA = 2'h2;
	localparam S_STOP = 2'h3;

	wire fifo_valid;
	wire fifo_ready;
	wire [7:0] fifo_data;
	reg fifo_pop;

	// Majority of three samples.
	function maj3;
		input [2:0] s;
		begin
			maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
		end
	endfunction

	// Next bit to shift out, honouring the bit order.
	function out_bit;
		input [7:0] d;
		input msb;
		begin
			out_bit = msb ? d[7] : d[0];
		end
	endfunction

	usart_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_in_valid(i_tx_valid),
		.o_in_ready(fifo_ready),
		.i_in_data(i_tx_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_data)
	);

	// Host SPI shifter state.
	reg spi_busy_q;
	reg half_q;
	reg [3:0] bit_cnt_q;
	reg [7:0] tx_sh_q;
	reg [7:0] rx_sh_q;
	reg sample_q;
	reg lead_q;
	wire [7:0] tx_next;

	// Pop a byte when the shifter is free on a baud tick.
	always @*
	begin
		fifo_pop = i_spi_mode && !spi_busy_q && fifo_valid && i_baud_tick;
	end

	// Shifter contents once the current bit has gone out.
	assign tx_next = i_bit_order_select ? {tx_sh_q[6:0], 1'b0}
		: {1'b0, tx_sh_q[7:1]};

	// Each tick toggles the clock phase; two ticks make one bit.
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			spi_busy_q <= 1'b0;
			half_q <= 1'b0;
			bit_cnt_q <= 4'h0;
			tx_sh_q <= 8'h00;
			rx_sh_q <= 8'h00;
			sample_q <= 1'b0;
			lead_q <= 1'b0;
			o_mosi <= 1'b1;
			o_transfer_clock_pin <= 1'b0;
			o_tx_done <= 1'b0;
			o_tx_empty <= 1'b1;
			o_tx_ready <= 1'b0;
		end
		else
		begin
			o_tx_done <= 1'b0;
			o_tx_ready <= fifo_ready;
			o_tx_empty <= !fifo_valid && !spi_busy_q;
			if (!i_spi_mode || !spi_busy_q)
				o_transfer_clock_pin <= i_pin_invert_select;
			if (fifo_pop)
			begin
				spi_busy_q <= 1'b1;
				half_q <= 1'b0;
				bit_cnt_q <= 4'h0;
				tx_sh_q <= fifo_data;
				// Phase 0 puts the first bit out before the leading edge.
				if (!i_clock_phase_select)
					o_mosi <= out_bit(fifo_data, i_bit_order_select);
			end
			else if (spi_busy_q && i_baud_tick)
			begin
				half_q <= !half_q;
				o_transfer_clock_pin <= i_pin_invert_select ^ !half_q;
				// Leading edge on first half, trailing on second.
				if (!half_q == !i_clock_phase_select)
				begin
					rx_sh_q <= i_bit_order_select ? {rx_sh_q[6:0], i_miso}
						: {i_miso, rx_sh_q[7:1]};
				end
				else
				begin
					// Phase 1 puts out the current bit, phase 0 the next one.
					if (i_clock_phase_select)
						o_mosi <= out_bit(tx_sh_q, i_bit_order_select);
					else if (bit_cnt_q != `SPI_FRAME_BITS - 4'h1)
						o_mosi <= out_bit(tx_next, i_bit_order_select);
					tx_sh_q <= tx_next;
				end
				if (half_q)
				begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (bit_cnt_q == `SPI_FRAME_BITS - 4'h1)
					begin
						spi_busy_q <= 1'b0;
						o_tx_done <= 1'b1;
						sample_q <= 1'b1;
					end
				end
			end
			else
				sample_q <= 1'b0;
			lead_q <= sample_q;
		end
	end

	// Async receiver state.
	reg [1:0] st_q;
	reg [4:0] smp_q;
	reg [3:0] rbit_q;
	reg [2:0] vote_q;
	reg [7:0] rdata_q;
	reg prev_q;
	wire [4:0] ovs;
	wire [4:0] vfirst;
	wire vote_now;

	// Oversample rate and vote position per speed mode.
	assign ovs = i_receive_speed_mode ? `OVS_DOUBLE : `OVS_NORMAL;
	assign vfirst = i_receive_speed_mode ? `VOTE_FIRST_DOUBLE
		: `VOTE_FIRST_NORMAL;

	// The third vote is the line itself at the deciding sample.
	assign vote_now = maj3({vote_q[1:0], i_rxd});

	// Receiver runs on the oversample tick.
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st_q <= S_IDLE;
			smp_q <= 5'h00;
			rbit_q <= 4'h0;
			vote_q <= 3'h7;
			rdata_q <= 8'h00;
			prev_q <= 1'b1;
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
			o_rx_frame_err <= 1'b0;
		end
		else
		begin
			o_rx_valid <= 1'b0;
			if (i_spi_mode)
			begin
				st_q <= S_IDLE;
				o_rx_frame_err <= 1'b0;
				if (lead_q)
				begin
					o_rx_valid <= 1'b1;
					o_rx_data <= rx_sh_q;
				end
			end
			else if (i_baud_tick)
			begin
				prev_q <= i_rxd;
				// Sample number runs from 1 to the rate within each bit.
				smp_q <= (smp_q >= ovs) ? 5'h01 : smp_q + 5'h01;
				if (smp_q >= vfirst && smp_q <= vfirst + 5'h02)
					vote_q <= {vote_q[1:0], i_rxd};
				case (st_q)
				S_IDLE:
				begin
					if (prev_q && !i_rxd)
					begin
						st_q <= S_START;
						smp_q <= 5'h02;
					end
				end
				S_START:
				begin
					if (smp_q == vfirst + 5'h02)
					begin
						if (vote_now)
							st_q <= S_IDLE;
						else
						begin
							st_q <= S_DATA;
							rbit_q <= 4'h0;
						end
					end
				end
				S_DATA:
				begin
					if (smp_q == vfirst + 5'h02)
					begin
						rdata_q <= {vote_now, rdata_q[7:1]};
						rbit_q <= rbit_q + 4'h1;
						if (rbit_q == `RX_DATA_BITS - 4'h1)
							st_q <= S_STOP;
					end
				end
				S_STOP:
				begin
					if (smp_q == vfirst + 5'h02)
					begin
						o_rx_valid <= 1'b1;
						o_rx_data <= rdata_q;
						o_rx_frame_err <= !vote_now;
						st_q <= S_IDLE;
						prev_q <= 1'b1;
					end
				end
				default:
					st_q <= S_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/usart_core_map.vh
// Purpose: Constants for the serial transceiver core.
// Assumes: One 10 MHz clock, no register bus.
// Notes: Counts are in bits, FIFO entries or oversamples.
`ifndef USART_CORE_MAP_VH
`define USART_CORE_MAP_VH
`define CLK_PERIOD_NS 100
`define SPI_FRAME_BITS 4'h8
`define OVS_NORMAL 5'h10
`define OVS_DOUBLE 5'h08
`define VOTE_FIRST_NORMAL 5'h08
`define VOTE_FIRST_DOUBLE 5'h04
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define RX_DATA_BITS 4'h8
`endif

// file: testbench/spi_client_model.sv
// Purpose: Behavioural SPI client, always selected.
// Assumes: Sends its byte MSB first.
// Notes: Exchange register shifts on each sampling edge.
`timescale 1ns/1ps
`default_nettype none
module spi_client_model (
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_inv,
	input wire logic i_phase,
	input wire logic i_load,
	input wire logic [7:0] i_load_data,
	output logic o_miso,
	output logic [7:0] o_got
);
	logic [7:0] sr_q;
	// Load presets the reply; a sampling edge shifts one bit in.
	always @(i_sck or posedge i_load)
		if (i_load)
			sr_q <= i_load_data;
		else if (i_sck == (i_inv ^ !i_phase))
			sr_q <= {sr_q[6:0], i_mosi};
	assign o_miso = sr_q[7];
	assign o_got = sr_q;
endmodule
`default_nettype wire

// file: testbench/usart_core_checker.sv
// Purpose: Port checks for the transceiver core.
// Assumes: Baud tick on every fourth clock.
// Notes: Bound to the core after the module.
`timescale 1ns/1ps
`default_nettype none
module usart_core_checker (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_baud_tick,
	input wire logic i_spi_mode,
	input wire logic i_pin_invert_select,
	input wire logic i_clock_phase_select,
	input wire logic o_tx_done,
	input wire logic o_tx_empty,
	input wire logic o_rx_valid,
	input wire logic o_rx_frame_err,
	input wire logic o_mosi,
	input wire logic o_transfer_clock_pin
);
	// Short names for the clock pin and its idle level.
	wire logic c = o_transfer_clock_pin;
	wire logic v = i_pin_invert_select;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	idle_clock_a: assert property (o_tx_empty && $past(o_tx_empty)
		&& $stable(v) |-> c == v) else $error("clock not idle");
	tick_edge_a: assert property ($changed(c) && $past(v, 2) == v
		|-> $past(i_baud_tick) || $past(i_baud_tick, 2))
		else $error("clock edge without tick");
	sample_hold_a: assert property ($changed(c)
		&& (c ^ v) != i_clock_phase_select |-> $stable(o_mosi))
		else $error("data moved on sample edge");
	half_period_a: assert property (i_spi_mode && $changed(c)
		|=> $stable(c) [*3]) else $error("clock half period short");
	spi_ferr_a: assert property (i_spi_mode && o_rx_valid
		|-> !o_rx_frame_err) else $error("frame error in host mode");
	ferr_hold_a: assert property (!i_spi_mode
		&& $changed(o_rx_frame_err) |-> o_rx_valid)
		else $error("frame error moved between frames");
	done_pulse_a: assert property (o_tx_done |=> !o_tx_done)
		else $error("done longer than one cycle");
	valid_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
		else $error("valid longer than one cycle");
endmodule
bind usart_core usart_core_checker chk (.i_sys_clk, .i_reset_n,
	.i_baud_tick, .i_spi_mode, .i_pin_invert_select,
	.i_clock_phase_select, .o_tx_done, .o_tx_empty, .o_rx_valid,
	.o_rx_frame_err, .o_mosi, .o_transfer_clock_pin);
`default_nettype wire

// file: testbench/usart_core_tb_top.sv
// Purpose: Self-checking bench for the transceiver core.
// Assumes: Baud tick every fourth clock.
// Notes: Host SPI modes, FIFO, then both receive speeds.
`timescale 1ns/1ps
`default_nettype none
module usart_core_tb_top;
	logic i_sys_clk = 0, i_reset_n = 0, i_baud_tick = 0, i_spi_mode = 1;
	logic i_pin_invert_select = 0, i_clock_phase_select = 0;
	logic i_bit_order_select = 0, i_receive_speed_mode = 0;
	logic i_tx_valid = 0, i_miso, i_rxd = 1, tick_en = 1, ld = 0;
	logic [7:0] i_tx_data = 8'h00, ld_data = 8'h00, o_rx_data, got;
	logic o_tx_ready, o_tx_done, o_tx_empty, o_rx_valid;
	logic o_rx_frame_err, o_mosi, o_transfer_clock_pin;
	logic [1:0] tick_cnt = 2'h0;
	logic [8:0] rxq[$];
	int n_fail = 0, checked = 0, done_cnt = 0;
	usart_core uut (.i_sys_clk, .i_reset_n, .i_baud_tick, .i_spi_mode,
		.i_pin_invert_select, .i_clock_phase_select, .i_bit_order_select,
		.i_receive_speed_mode, .i_tx_valid, .o_tx_ready, .i_tx_data,
		.o_tx_done, .o_tx_empty, .o_rx_valid, .o_rx_data, .o_rx_frame_err,
		.o_mosi, .i_miso, .o_transfer_clock_pin, .i_rxd);
	spi_client_model cli (.i_sck(o_transfer_clock_pin), .i_mosi(o_mosi),
		.i_inv(i_pin_invert_select), .i_phase(i_clock_phase_select),
		.i_load(ld), .i_load_data(ld_data), .o_miso(i_miso), .o_got(got));
	always #50 i_sys_clk = ~i_sys_clk;
	// Makes the tick, logs received bytes and counts finished frames.
	always @(posedge i_sys_clk)
	begin
		tick_cnt <= tick_cnt + 2'h1;
		i_baud_tick <= tick_en && tick_cnt == 2'h3;
		if (o_rx_valid) rxq.push_back({o_rx_frame_err, o_rx_data});
		if (o_tx_done) done_cnt++;
	end
	task chk(input string what, input logic [8:0] exp, input logic [8:0] g);
		checked++;
		if (g !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, g);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function logic [7:0] rev(input logic [7:0] b);
		for (int k = 0; k < 8; k++) rev[k] = b[7 - k];
	endfunction
	// Waits for n baud ticks.
	task wt(input int n);
		repeat (n)
		begin
			@(posedge i_sys_clk);
			while (!i_baud_tick) @(posedge i_sys_clk);
		end
	endtask
	// Waits, bounded, until the transmitter has drained.
	task wait_idle;
		int k;
		k = 0;
		repeat (3) @(posedge i_sys_clk);
		while (!o_tx_empty && k < 3000)
		begin
			@(posedge i_sys_clk);
			k++;
		end
		chk("idle", 9'h001, {8'h00, o_tx_empty});
		repeat (4) @(posedge i_sys_clk);
	endtask
	// One byte exchanged under mode bits {invert, phase, msb first}.
	task spi_xfer(input logic [2:0] m, input logic [7:0] tx, cv);
		{i_pin_invert_select, i_clock_phase_select, i_bit_order_select} <= m;
		ld <= 1;
		ld_data <= cv;
		repeat (8) @(posedge i_sys_clk);
		ld <= 0;
		i_tx_valid <= 1;
		i_tx_data <= tx;
		rxq.delete();
		@(posedge i_sys_clk);
		i_tx_valid <= 0;
		wait_idle;
		chk("rx", {1'b0, m[0] ? cv : rev(cv)}, rxq[0]);
		chk("client", {1'b0, m[0] ? tx : rev(tx)}, {1'b0, got});
	endtask
	// Fills the FIFO with ticks stopped, then drains it.
	task fifo_fill;
		int d0;
		d0 = done_cnt;
		tick_en <= 0;
		repeat (2) @(posedge i_sys_clk);
		i_tx_valid <= 1;
		for (int k = 0; k < 20; k++)
		begin
			i_tx_data <= k;
			@(posedge i_sys_clk);
		end
		i_tx_valid <= 0;
		chk("ready", 9'h000, {8'h00, o_tx_ready});
		tick_en <= 1;
		wait_idle;
		chk("done", 9'd16, done_cnt - d0);
		chk("last", 9'h00F, {1'b0, got});
	endtask
	// Sends one asynchronous frame, LSB first, stop held len ticks.
	task send(input int s, input logic [7:0] b, input logic st, input int len);
		i_rxd <= 0;
		wt(s);
		for (int k = 0; k < 8; k++)
		begin
			i_rxd <= b[k];
			wt(s);
		end
		i_rxd <= st;
		wt(len);
		i_rxd <= 1;
	endtask
	// Glitch, then a frame with shortest stop, then a bad stop bit.
	task async_rx(input logic dbl);
		int s;
		s = dbl ? 8 : 16;
		i_spi_mode <= 0;
		i_receive_speed_mode <= dbl;
		rxq.delete();
		wt(2 * s);
		i_rxd <= 0;
		wt(s / 2);
		i_rxd <= 1;
		wt(2 * s);
		send(s, 8'h4B, 1, s / 2 + 2);
		send(s, 8'hD2, 0, s);
		wt(2 * s);
		chk("frames", 9'd2, rxq.size());
		chk("frame0", 9'h04B, rxq[0]);
		chk("frame1", 9'h1D2, rxq[1]);
	endtask
	// Cuts a hang short.
	initial
	begin
		#3000000;
		n_fail++;
		finish_test;
	end
	// Main sequence.
	initial
	begin
		repeat (10) @(posedge i_sys_clk);
		i_reset_n <= 1;
		repeat (2) @(posedge i_sys_clk);
		for (int m = 0; m < 8; m++)
			spi_xfer(m, 8'hA5 ^ m, 8'h3C + m);
		fifo_fill;
		async_rx(0);
		async_rx(1);
		finish_test;
	end
endmodule
`default_nettype wire
